// ### design/spg_pkg.sv
// Package of offsets, fields, commands and reset values of the split pulse generator
package spg_pkg;

  // Register byte offsets
  localparam logic [7:0] SPG_OFF_CMD      = 8'h00;
  localparam logic [7:0] SPG_OFF_LENGTH   = 8'h04;
  localparam logic [7:0] SPG_OFF_WIDTH    = 8'h08;
  localparam logic [7:0] SPG_OFF_COUNT    = 8'h0C;
  localparam logic [7:0] SPG_OFF_MODE     = 8'h10;
  localparam logic [7:0] SPG_OFF_STATUS   = 8'h14;
  localparam logic [7:0] SPG_OFF_IRQ_EN   = 8'h18;
  localparam logic [7:0] SPG_OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] SPG_OFF_EMITTED  = 8'h20;

  // Command codes written to the command register
  localparam logic [7:0] SPG_CMD_START = 8'h75;
  localparam logic [7:0] SPG_CMD_TERM  = 8'h76;

  // Field positions
  localparam int SPG_BIT_SPLIT_BUSY = 13;
  localparam int SPG_BIT_POLARITY   = 10;
  localparam int SPG_BIT_LEADING    = 11;
  localparam int SPG_BIT_IRQ_EDGE   = 10;
  localparam int SPG_BIT_IRQ_DONE   = 11;

  // Interrupt source indices inside the two-bit status vector
  localparam int SPG_SRC_EDGE = 0;
  localparam int SPG_SRC_DONE = 1;
  localparam int SPG_NUM_SRC  = 2;

  // Reset values and unit constants
  localparam logic [15:0] SPG_LENGTH_RST = 16'h0002;
  localparam logic [15:0] SPG_WIDTH_RST  = 16'h0001;
  localparam logic [15:0] SPG_COUNT_RST  = 16'h0000;
  localparam logic [15:0] SPG_ONE        = 16'h0001;
  localparam logic [15:0] SPG_ZERO       = 16'h0000;

endpackage : spg_pkg

// ### design/spg_reg_if.sv
// Interface between the bus slave and the register file of the split pulse generator
`timescale 1ns/1ps
interface spg_reg_if;
  logic [7:0]  addr;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output addr, output wr, output wdata, input rdata);
  modport regs  (input addr, input wr, input wdata, output rdata);
endinterface : spg_reg_if

// ### design/spg_avs_slave.sv
// Avalon-MM slave with waitrequest feeding the register file
`timescale 1ns/1ps
module spg_avs_slave
  import spg_pkg::*;
(
  // Clock and reset
  input  logic        clk,
  input  logic        reset,
  // Avalon-MM slave
  input  logic [7:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Register side
  spg_reg_if.slave    rif
);

  logic wait_q;

  // Every access answers one cycle after it appears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_q <= 1'b0;
    end
  end

  // Read data captured on the first cycle, stands while waitrequest is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && wait_q) begin
      avs_readdata <= rif.rdata;
    end
  end

  // Write takes effect on the edge that sees waitrequest low
  assign avs_waitrequest = wait_q;
  assign rif.addr        = avs_address;
  assign rif.wdata       = avs_writedata;
  assign rif.wr          = avs_write && !wait_q;

endmodule : spg_avs_slave

// ### design/spg_irq.sv
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module spg_irq
  import spg_pkg::*;
#(
  parameter int W = 2
) (
  // Clock and reset
  input  logic         clk,
  input  logic         reset,
  // Events and software access
  input  logic [W-1:0] set,
  input  logic         clr_we,
  input  logic [W-1:0] clr_data,
  input  logic [W-1:0] mask,
  // Results
  output logic [W-1:0] status,
  output logic         irq
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= set | (status & ~(clr_we ? clr_data : '0));
    end
  end

  // Level output while any enabled bit is pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule : spg_irq

// ### design/spg_top.sv
// Split pulse generator locked to drive pulses, with registers and interrupt
`timescale 1ns/1ps
module spg_top
  import spg_pkg::*;
(
  // Clock and reset
  input  logic        clk,
  input  logic        reset,
  // Avalon-MM slave
  input  logic [7:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Pulse generator side
  input  logic        drive_pulse,
  input  logic        driving,
  // Synchronous action requests
  input  logic        sync_start,
  input  logic        sync_stop,
  input  logic        sync_load,
  input  logic [15:0] sync_load_length,
  input  logic [15:0] sync_load_width,
  // Split output and events
  output logic        split_pin,
  output logic        evt_started,
  output logic        evt_pulse,
  output logic        evt_ended,
  output logic        irq
);

  spg_reg_if rif ();
  // Settings
  logic [15:0] len_q;
  logic [15:0] wid_q;
  logic [15:0] cnt_q;
  logic        pol_q;
  logic        lead_q;
  logic [1:0]  mask_q;
  // Engine state
  logic        act_q,   act_d;
  logic        out_q,   out_d;
  logic        first_q, first_d;
  logic        skip_q,  skip_d;
  logic        term_q,  term_d;
  logic [15:0] pos_q,   pos_d;
  logic [15:0] emit_q,  emit_d;
  logic        driving_q;
  // Event terms
  logic        ended_c;
  logic        edge_c;
  logic        cmd_start;
  logic        cmd_term;
  logic        start_req;
  logic        term_req;
  logic        drive_stop;
  logic [1:0]  irq_status;
  logic [31:0] rdata_c;

  // Last position of a split period
  function automatic logic [15:0] last_pos(input logic [15:0] len);
    last_pos = len - SPG_ONE;
  endfunction : last_pos

  // Test for a write of a value to one register offset
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] off);
    wr_hit = wr && (addr == off);
  endfunction : wr_hit

  spg_avs_slave u_slave (
    .clk             (clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rif             (rif.slave)
  );

  spg_irq #(.W(SPG_NUM_SRC)) u_irq (
    .clk      (clk),
    .reset    (reset),
    .set      ({ended_c, edge_c}),
    .clr_we   (wr_hit(rif.wr, rif.addr, SPG_OFF_IRQ_STAT)),
    .clr_data ({rif.wdata[SPG_BIT_IRQ_DONE], rif.wdata[SPG_BIT_IRQ_EDGE]}),
    .mask     (mask_q),
    .status   (irq_status),
    .irq      (irq)
  );

  // Commands and requests from software and synchronous actions
  assign cmd_start  = wr_hit(rif.wr, rif.addr, SPG_OFF_CMD)
                      && (rif.wdata[7:0] == SPG_CMD_START);
  assign cmd_term   = wr_hit(rif.wr, rif.addr, SPG_OFF_CMD)
                      && (rif.wdata[7:0] == SPG_CMD_TERM);
  assign start_req  = cmd_start || sync_start;
  assign term_req   = cmd_term || sync_stop;
  assign drive_stop = driving_q && !driving;

  // Length and width, from software or a synchronous load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      len_q <= SPG_LENGTH_RST;
      wid_q <= SPG_WIDTH_RST;
    end else if (sync_load) begin
      len_q <= sync_load_length;
      wid_q <= sync_load_width;
    end else begin
      if (wr_hit(rif.wr, rif.addr, SPG_OFF_LENGTH)) begin
        len_q <= rif.wdata[15:0];
      end
      if (wr_hit(rif.wr, rif.addr, SPG_OFF_WIDTH)) begin
        wid_q <= rif.wdata[15:0];
      end
    end
  end

  // Pulse count, mode and interrupt enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= SPG_COUNT_RST;
      pol_q  <= 1'b0;
      lead_q <= 1'b0;
      mask_q <= 2'h0;
    end else begin
      if (wr_hit(rif.wr, rif.addr, SPG_OFF_COUNT)) begin
        cnt_q <= rif.wdata[15:0];
      end
      if (wr_hit(rif.wr, rif.addr, SPG_OFF_MODE)) begin
        pol_q  <= rif.wdata[SPG_BIT_POLARITY];
        lead_q <= rif.wdata[SPG_BIT_LEADING];
      end
      if (wr_hit(rif.wr, rif.addr, SPG_OFF_IRQ_EN)) begin
        mask_q <= {rif.wdata[SPG_BIT_IRQ_DONE], rif.wdata[SPG_BIT_IRQ_EDGE]};
      end
    end
  end

  // Read back mux, unmapped offsets read zero
  always_comb begin
    rdata_c = 32'h00000000;
    case (rif.addr)
      SPG_OFF_LENGTH:  rdata_c[15:0] = len_q;
      SPG_OFF_WIDTH:   rdata_c[15:0] = wid_q;
      SPG_OFF_COUNT:   rdata_c[15:0] = cnt_q;
      SPG_OFF_EMITTED: rdata_c[15:0] = emit_q;
      SPG_OFF_MODE: begin
        rdata_c[SPG_BIT_POLARITY] = pol_q;
        rdata_c[SPG_BIT_LEADING]  = lead_q;
      end
      SPG_OFF_STATUS:  rdata_c[SPG_BIT_SPLIT_BUSY] = act_q;
      SPG_OFF_IRQ_EN: begin
        rdata_c[SPG_BIT_IRQ_EDGE] = mask_q[SPG_SRC_EDGE];
        rdata_c[SPG_BIT_IRQ_DONE] = mask_q[SPG_SRC_DONE];
      end
      SPG_OFF_IRQ_STAT: begin
        rdata_c[SPG_BIT_IRQ_EDGE] = irq_status[SPG_SRC_EDGE];
        rdata_c[SPG_BIT_IRQ_DONE] = irq_status[SPG_SRC_DONE];
      end
      default: rdata_c = 32'h00000000;
    endcase
  end
  assign rif.rdata = rdata_c;

  // Next state of the split engine
  always_comb begin
    act_d   = act_q;
    out_d   = out_q;
    first_d = first_q;
    skip_d  = skip_q;
    term_d  = term_q;
    pos_d   = pos_q;
    emit_d  = emit_q;
    ended_c = 1'b0;
    if (start_req) begin
      // Arm; status rises now, output waits for drive pulses
      act_d   = 1'b1;
      first_d = 1'b1;
      skip_d  = !lead_q;
      emit_d  = SPG_ZERO;
      term_d  = 1'b0;
      out_d   = 1'b0;
      pos_d   = SPG_ZERO;
    end else if (act_q) begin
      if (drive_stop) begin
        act_d   = 1'b0;
        out_d   = 1'b0;
        ended_c = 1'b1;
      end else begin
        if (drive_pulse) begin
          if (first_q) begin
            pos_d   = SPG_ZERO;
            first_d = 1'b0;
          end else if (pos_q >= last_pos(len_q)) begin
            pos_d  = SPG_ZERO;
            skip_d = 1'b0;
          end else begin
            pos_d = pos_q + SPG_ONE;
          end
          // Active for the width, idle for the rest of the period
          out_d = !skip_d && (pos_d < wid_q);
          if (out_d && !out_q) begin
            emit_d = emit_q + SPG_ONE;
          end
          if (term_q && !first_q && (pos_d == last_pos(len_q))) begin
            act_d   = 1'b0;
            out_d   = 1'b0;
            ended_c = 1'b1;
          end else if ((cnt_q != SPG_ZERO) && (emit_q == cnt_q)
                       && out_q && !out_d) begin
            act_d   = 1'b0;
            ended_c = 1'b1;
          end
        end
        if (term_req && act_d) begin
          if (!out_d) begin
            act_d   = 1'b0;
            ended_c = 1'b1;
          end else begin
            term_d = 1'b1;
          end
        end
      end
    end
  end
  assign edge_c = out_d && !out_q;

  // Engine registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_q   <= 1'b0;
      out_q   <= 1'b0;
      first_q <= 1'b0;
      skip_q  <= 1'b0;
      term_q  <= 1'b0;
      pos_q   <= SPG_ZERO;
      emit_q  <= SPG_ZERO;
    end else begin
      act_q   <= act_d;
      out_q   <= out_d;
      first_q <= first_d;
      skip_q  <= skip_d;
      term_q  <= term_d;
      pos_q   <= pos_d;
      emit_q  <= emit_d;
    end
  end

  // Driving level history for stop detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      driving_q <= 1'b0;
    end else begin
      driving_q <= driving;
    end
  end

  // Pin with polarity applied, inactive after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      split_pin <= 1'b0;
    end else begin
      split_pin <= out_d ^ pol_q;
    end
  end

  // Synchronous action factor strobes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_started <= 1'b0;
      evt_pulse   <= 1'b0;
      evt_ended   <= 1'b0;
    end else begin
      evt_started <= start_req;
      evt_pulse   <= edge_c;
      evt_ended   <= ended_c;
    end
  end

  // Status follows a start on the next edge
  chk_start_sets_status: assert property (
    @(posedge clk) disable iff (reset)
    start_req |=> act_q && !out_q && (emit_q == SPG_ZERO))
    else $error("status or count wrong after start");
  // Restart clears the emitted count
  chk_restart_count_clear: assert property (
    @(posedge clk) disable iff (reset)
    act_q && start_req |=> emit_q == SPG_ZERO)
    else $error("restart did not clear emitted count");
  // A stop of driving ends operation with the output off
  chk_drive_stop_off: assert property (
    @(posedge clk) disable iff (reset)
    act_q && drive_stop && !start_req |=> !act_q && !out_q && evt_ended)
    else $error("drive stop did not end split operation");
  // Terminate with output inactive ends at once
  chk_term_idle_now: assert property (
    @(posedge clk) disable iff (reset)
    act_q && term_req && !out_q && !drive_pulse && !start_req && !drive_stop
    |=> !act_q)
    else $error("terminate while inactive did not stop");
  // Terminate while active keeps the pulse running
  chk_term_active_holds: assert property (
    @(posedge clk) disable iff (reset)
    act_q && out_q && term_req && !drive_pulse && !start_req && !drive_stop
    |=> act_q && out_q)
    else $error("terminate cut an active pulse");
  // Output idle whenever operation is off
  chk_idle_inactive: assert property (
    @(posedge clk) disable iff (reset)
    !act_q |-> !out_q)
    else $error("split output active while stopped");
  // Pin follows logical output with the programmed sense
  chk_pin_polarity: assert property (
    @(posedge clk) disable iff (reset)
    $stable(pol_q) |-> split_pin == (out_q ^ pol_q))
    else $error("split pin polarity mismatch");
  // Last counted pulse falling ends operation
  chk_count_end: assert property (
    @(posedge clk) disable iff (reset)
    $fell(out_q) && $past(act_q) && !$past(start_req) && (cnt_q != SPG_ZERO)
    && (emit_q == cnt_q) && $stable(cnt_q) |-> !act_q)
    else $error("operation continued after last pulse");
  // Output changes only on drive pulses, driving stops or starts
  chk_output_drive_locked: assert property (
    @(posedge clk) disable iff (reset)
    !drive_pulse && !drive_stop && !start_req |=> $stable(out_q))
    else $error("split output moved without a drive pulse");
  // Each pulse rise raises the interrupt two edges later when enabled
  chk_edge_irq: assert property (
    @(posedge clk) disable iff (reset)
    edge_c && mask_q[SPG_SRC_EDGE] && $stable(mask_q) ##1 $stable(mask_q)
    |=> irq)
    else $error("pulse interrupt missing");
  // End of operation raises the interrupt when enabled
  chk_done_irq: assert property (
    @(posedge clk) disable iff (reset)
    ended_c && mask_q[SPG_SRC_DONE] && $stable(mask_q) ##1 $stable(mask_q)
    |=> irq)
    else $error("end interrupt missing");
  // Active phase never exceeds the programmed width
  chk_width_bound: assert property (
    @(posedge clk) disable iff (reset)
    out_q |-> pos_q < wid_q)
    else $error("pulse active past its width");

endmodule : spg_top

// ### sim/spg_equip_model.sv
// Equipment model that counts split pulses on their active edge
`timescale 1ns/1ps
module spg_equip_model (
  // Clock and reset
  input  logic        clk,
  input  logic        reset,
  // Split output and its sense
  input  logic        split_pin,
  input  logic        polarity,
  // Trigger count
  output logic [15:0] trig_q
);
  logic pin_q;

  // Count each pin change into the active level; a sense change alone is no trigger
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_q  <= 1'b0;
      trig_q <= 16'h0000;
    end else begin
      pin_q <= split_pin;
      if ((split_pin != pin_q) && (split_pin != polarity)) begin
        trig_q <= trig_q + 16'h0001;
      end
    end
  end
endmodule : spg_equip_model

// ### sim/split_pulse_generator_tb.sv
// Self-checking bench for the split pulse generator
`timescale 1ns/1ps
module split_pulse_generator_tb;
  import spg_pkg::*;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, drive_pulse, driving;
  logic        sync_start, sync_stop, sync_load, split_pin, pol, irq;
  logic        evt_started, evt_pulse, evt_ended;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] sync_load_length, sync_load_width, trig;
  int          failures, checks, cyc, n_start, n_end, n_pulse;
  logic [7:0]  offs [9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30};
  logic [31:0] rsts [9] = '{32'h2, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  spg_top dut_u (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_pulse(drive_pulse), .driving(driving),
    .sync_start(sync_start), .sync_stop(sync_stop), .sync_load(sync_load),
    .sync_load_length(sync_load_length), .sync_load_width(sync_load_width),
    .split_pin(split_pin), .evt_started(evt_started), .evt_pulse(evt_pulse),
    .evt_ended(evt_ended), .irq(irq));
  spg_equip_model eq_u (.clk(clk), .reset(reset), .split_pin(split_pin), .polarity(pol),
    .trig_q(trig));

  // Clock and cycle limit
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // Event strobe counters
  always @(posedge clk) begin
    n_start += int'(evt_started === 1'b1);
    n_end += int'(evt_ended === 1'b1);
    n_pulse += int'(evt_pulse === 1'b1);
  end

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk

  task automatic cfg(input int l, input int w, input int n, input logic [31:0] mode);
    wr(SPG_OFF_LENGTH, l);
    wr(SPG_OFF_WIDTH, w);
    wr(SPG_OFF_COUNT, n);
    wr(SPG_OFF_MODE, mode);
    pol <= mode[SPG_BIT_POLARITY];
  endtask : cfg

  // One drive pulse, then the split output is compared
  task automatic pulse(input logic on);
    @(posedge clk);
    drive_pulse <= 1'b1;
    @(posedge clk);
    drive_pulse <= 1'b0;
    #1 chk("split_pin", {31'h0, on ^ pol}, {31'h0, split_pin});
  endtask : pulse

  // Drive pulses a..b of one sequence with the expected on/off pattern
  task automatic run(input int l, input int w, input bit lead, input int a, input int b);
    for (int i = a; i <= b; i++) begin
      pulse(lead ? ((i - 1) % l < w) : (i > l && (i - 1 - l) % l < w));
    end
  endtask : run

  task automatic strobe(input int k);
    @(posedge clk);
    sync_start <= (k == 0);
    sync_stop <= (k == 1);
    sync_load <= (k == 2);
    @(posedge clk);
    {sync_start, sync_stop, sync_load} <= 3'b000;
  endtask : strobe

  initial begin
    clk = 0;
    reset = 1;
    {avs_read, avs_write, drive_pulse, driving, sync_start, sync_stop, sync_load} = '0;
    {avs_address, avs_writedata, sync_load_length, sync_load_width, pol} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 chk("pin_rst", 32'h0, {31'h0, split_pin});
    for (int i = 0; i < 9; i++) rdchk("reg_rst", offs[i], rsts[i]);
    // Counted run started before driving, with interrupts
    wr(SPG_OFF_IRQ_EN, 32'hC00);
    cfg(4, 2, 2, 32'h800);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    rdchk("status", SPG_OFF_STATUS, 32'h2000);
    chk("pin_idle", 32'h0, {31'h0, split_pin});
    driving <= 1'b1;
    run(4, 2, 1, 1, 6);
    rdchk("status", SPG_OFF_STATUS, 32'h2000);
    pulse(0);
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    pulse(0);
    rdchk("emitted", SPG_OFF_EMITTED, 32'h2);
    rdchk("irq_stat", SPG_OFF_IRQ_STAT, 32'hC00);
    chk("irq", 32'h1, {31'h0, irq});
    wr(SPG_OFF_IRQ_STAT, 32'h400);
    rdchk("irq_stat", SPG_OFF_IRQ_STAT, 32'h800);
    chk("irq", 32'h1, {31'h0, irq});
    wr(SPG_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq_mask", 32'h0, {31'h0, irq});
    wr(SPG_OFF_IRQ_STAT, 32'h800);
    rdchk("irq_stat", SPG_OFF_IRQ_STAT, 32'h0);
    // No leading pulse
    cfg(3, 1, 1, 32'h0);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    run(3, 1, 0, 1, 5);
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    // Terminate while inactive, then while active
    cfg(4, 2, 0, 32'h800);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    run(4, 2, 1, 1, 3);
    wr(SPG_OFF_CMD, SPG_CMD_TERM);
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    pulse(0);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    run(4, 2, 1, 1, 9);
    wr(SPG_OFF_CMD, SPG_CMD_TERM);
    run(4, 2, 1, 10, 11);
    rdchk("status", SPG_OFF_STATUS, 32'h2000);
    pulse(0);
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    // Driving stops while output is active
    wr(SPG_OFF_CMD, SPG_CMD_START);
    pulse(1);
    driving <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("pin_stop", 32'h0, {31'h0, split_pin});
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    driving <= 1'b1;
    // Synchronous start, load and terminate
    sync_load_length <= 16'h0002;
    sync_load_width <= 16'h0001;
    strobe(0);
    #1 rdchk("status", SPG_OFF_STATUS, 32'h2000);
    strobe(2);
    run(2, 1, 1, 1, 4);
    rdchk("length", SPG_OFF_LENGTH, 32'h2);
    strobe(1);
    #1 rdchk("status", SPG_OFF_STATUS, 32'h0);
    chk("trig", 32'd10, {16'h0, trig});
    // Restart counts from one, negative sense
    cfg(3, 1, 3, 32'hC00);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    run(3, 1, 1, 1, 3);
    wr(SPG_OFF_CMD, SPG_CMD_TERM);
    wr(SPG_OFF_CMD, SPG_CMD_START);
    rdchk("emitted", SPG_OFF_EMITTED, 32'h0);
    run(3, 1, 1, 1, 7);
    rdchk("status", SPG_OFF_STATUS, 32'h2000);
    pulse(0);
    rdchk("status", SPG_OFF_STATUS, 32'h0);
    rdchk("emitted", SPG_OFF_EMITTED, 32'h3);
    repeat (3) @(posedge clk);
    chk("evt_started", 32'd8, n_start);
    chk("evt_ended", 32'd8, n_end);
    chk("evt_pulse", 32'd14, n_pulse);
    chk("trig_neg", 32'd14, {16'h0, trig});
    test_done();
  end
endmodule : split_pulse_generator_tb
